// ### logic/rfcs_pkg.sv
/*
  Shared constants for the RFID channel command sequencer: modes, command codes,
  response codes, limits and timing. Assumes a single 200 MHz clock.
*/
package rfcs_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_BYTES     = 128;
  localparam int NUM_HEADS     = 32;
  localparam int FIFO_DEPTH    = 16;
  localparam int FIFO_WIDTH    = 8;

  localparam logic [2:0] MODE_HF_BASIC  = 3'h0;
  localparam logic [2:0] MODE_HF_FULL   = 3'h1;
  localparam logic [2:0] MODE_HF_BUS    = 3'h2;
  localparam logic [2:0] MODE_UHF_BASIC = 3'h3;
  localparam logic [2:0] MODE_UHF_FULL  = 3'h4;

  localparam logic [7:0] CMD_IDLE       = 8'h00;
  localparam logic [7:0] CMD_INVENTORY  = 8'h01;
  localparam logic [7:0] CMD_READ       = 8'h02;
  localparam logic [7:0] CMD_WRITE      = 8'h04;
  localparam logic [7:0] CMD_WRITE_VFY  = 8'h05;
  localparam logic [7:0] CMD_TAG_INFO   = 8'h06;
  localparam logic [7:0] CMD_REPEAT     = 8'h10;
  localparam logic [7:0] CMD_BUF_READ   = 8'h11;
  localparam logic [7:0] CMD_STOP       = 8'h12;
  localparam logic [7:0] CMD_BUF_CLEAR  = 8'h13;
  localparam logic [7:0] CMD_HEAD_IDENT = 8'h20;
  localparam logic [7:0] CMD_HEAD_PW    = 8'h21;
  localparam logic [7:0] CMD_TAG_PW     = 8'h22;
  localparam logic [7:0] CMD_TAG_PROT   = 8'h23;
  localparam logic [7:0] CMD_ATTR_READ  = 8'h30;
  localparam logic [7:0] CMD_ATTR_WRITE = 8'h31;
  localparam logic [7:0] CMD_ATTR_LOCK  = 8'h32;
  localparam logic [7:0] CMD_RESET      = 8'h80;

  localparam logic [7:0] RESP_REJECT    = 8'hee;
  localparam logic [7:0] RESP_TIMEOUT   = 8'hef;
  localparam logic [7:0] RESP_RESET_VAL = 8'h00;
endpackage

// ### logic/rfcs_fifo_if.sv
/*
  Valid/ready carrier between the sequencer and its result buffer.
  Assumes both ends share one clock.
*/
interface rfcs_fifo_if #(parameter int W = 8, parameter int D = 16);
  logic                 in_valid;
  logic                 in_ready;
  logic [W-1:0]         in_data;
  logic                 out_valid;
  logic                 out_ready;
  logic [W-1:0]         out_data;
  logic                 flush;
  logic                 ring;
  logic [$clog2(D):0]   count;
  modport store (input in_valid, in_data, out_ready, flush, ring,
                 output in_ready, out_valid, out_data, count);
  modport user  (output in_valid, in_data, out_ready, flush, ring,
                 input in_ready, out_valid, out_data, count);
endinterface

// ### logic/rfcs_fifo.sv
/*
  Result buffer: first-in first-out, or a ring that drops its oldest word when full.
  Assumes D is a power of two and one clock with asynchronous active-low reset.
*/
module rfcs_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic   mclk,
  input wire logic   rstn,
  rfcs_fifo_if.store f
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          full;
  logic          push;
  logic          pop;
  logic          drop;

  assign full        = (cnt_reg == AW'(0) + (AW+1)'(D));
  // In ring mode a full buffer still accepts data, so the writer never stalls.
  assign f.in_ready  = f.ring || !full;
  assign f.out_valid = (cnt_reg != '0);
  assign f.out_data  = mem[rp_reg];
  assign f.count     = cnt_reg;
  assign push        = f.in_valid && f.in_ready;
  assign pop         = f.out_valid && f.out_ready;
  assign drop        = push && full && !pop;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_reg] <= f.in_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else if (f.flush) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + AW'(1);
      end
      if (pop || drop) begin
        rp_reg <= rp_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop || drop);
    end
  end
endmodule

// ### logic/rfcs_sequencer.sv
/*
  Per-channel command sequencer: takes controller commands, drives one head or a
  bus of heads, buffers results and reports echo or error codes. Assumes the
  controller side is logic on mclk and the head side signals are asynchronous.
*/
module rfcs_sequencer #(
  parameter int NH = rfcs_pkg::NUM_HEADS,
  parameter int FD = rfcs_pkg::FIFO_DEPTH
) (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic [2:0]            mode,
  input  wire logic                  multi_tag,
  input  wire logic [7:0]            cmd_code,
  input  wire logic [7:0]            rep_cmd,
  input  wire logic [7:0]            loop_cnt,
  input  wire logic [7:0]            frag_size,
  input  wire logic [$clog2(NH)-1:0] cmd_head,
  input  wire logic [15:0]           tmo_cfg,
  input  wire logic                  res_ready,
  output logic [7:0]                 resp_code,
  output logic [7:0]                 resp_loop,
  output logic                       resp_err,
  output logic                       resp_busy,
  output logic                       resp_trunc,
  output logic [7:0]                 frag_cnt,
  output logic                       rep_active,
  output logic [7:0]                 res_data,
  output logic                       res_valid,
  output logic                       head_req,
  output logic                       head_abort,
  output logic [7:0]                 head_cmd,
  output logic [$clog2(NH)-1:0]      head_addr,
  output logic                       head_all,
  output logic                       head_hold,
  output logic                       reader_on,
  input  wire logic                  head_done_tgl,
  input  wire logic                  head_ok,
  input  wire logic                  head_dv_tgl,
  input  wire logic [7:0]            head_data,
  input  wire logic [NH-1:0]         tag_in,
  output logic [NH-1:0]              tag_present
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DONE} rfcs_state_t;

  function automatic logic is_local(input logic [7:0] c);
    return c == rfcs_pkg::CMD_IDLE || c == rfcs_pkg::CMD_BUF_READ ||
           c == rfcs_pkg::CMD_STOP || c == rfcs_pkg::CMD_BUF_CLEAR ||
           c == rfcs_pkg::CMD_RESET;
  endfunction

  function automatic logic rep_ok(input logic [7:0] c);
    return c == rfcs_pkg::CMD_INVENTORY || c == rfcs_pkg::CMD_TAG_INFO ||
           c == rfcs_pkg::CMD_READ || c == rfcs_pkg::CMD_WRITE;
  endfunction

  function automatic logic is_full(input logic [2:0] m);
    return m == rfcs_pkg::MODE_HF_FULL || m == rfcs_pkg::MODE_UHF_FULL;
  endfunction

  function automatic logic cmd_allowed(input logic [7:0] c, input logic [2:0] m,
                                       input logic mt, input logic [7:0] r);
    logic ok;
    ok = is_local(c) || rep_ok(c) || c == rfcs_pkg::CMD_WRITE_VFY ||
         c == rfcs_pkg::CMD_HEAD_IDENT || c == rfcs_pkg::CMD_HEAD_PW ||
         c == rfcs_pkg::CMD_TAG_PW || c == rfcs_pkg::CMD_TAG_PROT ||
         c == rfcs_pkg::CMD_ATTR_READ || c == rfcs_pkg::CMD_ATTR_WRITE ||
         c == rfcs_pkg::CMD_ATTR_LOCK || c == rfcs_pkg::CMD_REPEAT;
    if (c == rfcs_pkg::CMD_REPEAT) begin
      ok = rep_ok(r) && (is_full(m) || m == rfcs_pkg::MODE_HF_BUS);
    end
    if (mt && is_full(m) && !(is_local(c) || rep_ok(c) || c == rfcs_pkg::CMD_REPEAT)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  localparam int SW = NH + 11;
  localparam int BW = 16;
  localparam int TW = $clog2(rfcs_pkg::TICK_CYC);
  localparam int CW = $clog2(FD) + 1;

  rfcs_fifo_if #(.W(rfcs_pkg::FIFO_WIDTH), .D(FD)) fq ();

  rfcs_fifo #(.W(rfcs_pkg::FIFO_WIDTH), .D(FD)) u_fifo (
    .mclk (mclk),
    .rstn (rstn),
    .f    (fq.store)
  );

  rfcs_state_t      st_reg;
  logic [SW-1:0]    s1_reg;
  logic [SW-1:0]    s2_reg;
  logic             dv3_reg;
  logic             done3_reg;
  logic [TW-1:0]    tick_reg;
  logic             tick;
  logic [15:0]      tmo_reg;
  logic             tmo_en_reg;
  logic [7:0]       last_cmd_reg;
  logic [7:0]       last_loop_reg;
  logic             flush_reg;
  logic [BW-1:0]    byte_cnt_reg;
  logic [7:0]       frag_in_reg;
  logic             push_v_reg;
  logic [7:0]       push_d_reg;
  logic             dv_ev;
  logic             done_ev;
  logic             cmd_new;
  logic             cmd_take;
  logic             tmo_hit;
  logic             bus_mode;
  logic             basic_mode;

  assign dv_ev      = s2_reg[1] ^ dv3_reg;
  assign done_ev    = s2_reg[0] ^ done3_reg;
  assign bus_mode   = (mode == rfcs_pkg::MODE_HF_BUS);
  assign basic_mode = (mode == rfcs_pkg::MODE_HF_BASIC) || (mode == rfcs_pkg::MODE_UHF_BASIC);
  // A changed code, or a bumped loop counter on a held code other than idle, starts a new run.
  assign cmd_new    = (cmd_code != last_cmd_reg) ||
                      (loop_cnt != last_loop_reg && cmd_code != rfcs_pkg::CMD_IDLE);
  // While repeating, only buffer and stop style commands get through.
  assign cmd_take   = cmd_new && (!rep_active ||
                      (is_local(cmd_code) && cmd_code != rfcs_pkg::CMD_IDLE));
  assign tmo_hit    = tmo_en_reg && (tmo_reg == 16'h0000);
  assign tick       = (tick_reg == TW'(rfcs_pkg::TICK_CYC - 1));

  assign fq.in_valid  = push_v_reg;
  assign fq.in_data   = push_d_reg;
  assign fq.flush     = flush_reg;
  assign fq.ring      = bus_mode && rep_active;
  assign fq.out_ready = (!res_valid || res_ready) && !flush_reg;

  // The data bits settle before their toggle is seen, so one sample is coherent.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      dv3_reg   <= 1'b0;
      done3_reg <= 1'b0;
    end else begin
      s1_reg    <= {tag_in, head_data, head_ok, head_dv_tgl, head_done_tgl};
      s2_reg    <= s1_reg;
      dv3_reg   <= s2_reg[1];
      done3_reg <= s2_reg[0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick_reg <= '0;
    end else if (tick) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + TW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tag_present <= '0;
    end else if (bus_mode) begin
      tag_present <= s2_reg[SW-1:11];
    end else begin
      tag_present <= {{(NH-1){1'b0}}, s2_reg[11]};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg        <= ST_IDLE;
      last_cmd_reg  <= rfcs_pkg::CMD_IDLE;
      last_loop_reg <= '0;
      resp_code     <= rfcs_pkg::RESP_RESET_VAL;
      resp_loop     <= '0;
      resp_err      <= 1'b0;
      resp_busy     <= 1'b0;
      rep_active    <= 1'b0;
      head_req      <= 1'b0;
      head_abort    <= 1'b0;
      head_cmd      <= rfcs_pkg::CMD_IDLE;
      head_addr     <= '0;
      head_all      <= 1'b0;
      reader_on     <= 1'b0;
      tmo_reg       <= '0;
      tmo_en_reg    <= 1'b0;
      flush_reg     <= 1'b0;
    end else begin
      head_req   <= 1'b0;
      head_abort <= 1'b0;
      flush_reg  <= 1'b0;
      unique case (st_reg)
        ST_IDLE: begin
          if (cmd_take) begin
            last_cmd_reg  <= cmd_code;
            last_loop_reg <= loop_cnt;
            resp_loop     <= loop_cnt;
            if (!cmd_allowed(cmd_code, mode, multi_tag, rep_cmd)) begin
              resp_code <= rfcs_pkg::RESP_REJECT;
              resp_err  <= 1'b1;
            end else if (is_local(cmd_code)) begin
              resp_code <= cmd_code;
              resp_err  <= 1'b0;
              if (cmd_code == rfcs_pkg::CMD_STOP || cmd_code == rfcs_pkg::CMD_RESET) begin
                rep_active <= 1'b0;
                reader_on  <= 1'b0;
              end
              if (cmd_code == rfcs_pkg::CMD_BUF_CLEAR || cmd_code == rfcs_pkg::CMD_RESET) begin
                flush_reg <= 1'b1;
              end
            end else begin
              rep_active <= (cmd_code == rfcs_pkg::CMD_REPEAT);
              head_cmd   <= (cmd_code == rfcs_pkg::CMD_REPEAT) ? rep_cmd : cmd_code;
              resp_busy  <= 1'b1;
              st_reg     <= ST_ISSUE;
            end
          end else if (rep_active) begin
            resp_busy <= 1'b1;
            st_reg    <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          head_req   <= 1'b1;
          // Plain bus mode addresses one head; the continuous variant broadcasts.
          head_addr  <= (bus_mode && !rep_active) ? cmd_head : '0;
          head_all   <= bus_mode && rep_active;
          reader_on  <= mode == rfcs_pkg::MODE_UHF_FULL || mode == rfcs_pkg::MODE_UHF_BASIC;
          tmo_reg    <= tmo_cfg;
          tmo_en_reg <= is_full(mode) && (tmo_cfg != 16'h0000);
          st_reg     <= ST_WAIT;
        end
        ST_WAIT: begin
          if (done_ev) begin
            resp_code <= s2_reg[2] ? head_cmd : rfcs_pkg::RESP_REJECT;
            resp_err  <= !s2_reg[2];
            st_reg    <= ST_DONE;
          end else if (tmo_hit) begin
            head_abort <= 1'b1;
            resp_code  <= rfcs_pkg::RESP_TIMEOUT;
            resp_err   <= 1'b1;
            st_reg     <= ST_DONE;
          end else if (tick && tmo_en_reg) begin
            tmo_reg <= tmo_reg - 16'h0001;
          end
        end
        ST_DONE: begin
          resp_busy  <= 1'b0;
          head_all   <= 1'b0;
          tmo_en_reg <= 1'b0;
          reader_on  <= 1'b0;
          st_reg     <= ST_IDLE;
        end
      endcase
    end
  end

  // Result bytes flow to the buffer; basic modes cap a transaction at the limit.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      byte_cnt_reg <= '0;
      frag_in_reg  <= '0;
      frag_cnt     <= '0;
      resp_trunc   <= 1'b0;
      push_v_reg   <= 1'b0;
      push_d_reg   <= '0;
      head_hold    <= 1'b0;
    end else begin
      push_v_reg <= 1'b0;
      // Hold two words early: a byte already toggled at the head lands after the hold is seen.
      head_hold  <= !fq.ring && (fq.count >= CW'(FD - 2));
      if (st_reg == ST_ISSUE) begin
        byte_cnt_reg <= '0;
        frag_in_reg  <= '0;
        frag_cnt     <= '0;
        resp_trunc   <= 1'b0;
      end else if (st_reg == ST_WAIT && dv_ev) begin
        if (basic_mode && byte_cnt_reg == BW'(rfcs_pkg::MAX_BYTES)) begin
          resp_trunc <= 1'b1;
        end else begin
          push_v_reg   <= 1'b1;
          push_d_reg   <= s2_reg[10:3];
          byte_cnt_reg <= byte_cnt_reg + BW'(1);
          if (!basic_mode && frag_size != 8'h00 && frag_in_reg + 8'h01 == frag_size) begin
            frag_in_reg <= '0;
            frag_cnt    <= frag_cnt + 8'h01;
          end else begin
            frag_in_reg <= frag_in_reg + 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      res_valid <= 1'b0;
      res_data  <= '0;
    end else if (flush_reg) begin
      res_valid <= 1'b0;
    end else if (!res_valid || res_ready) begin
      res_valid <= fq.out_valid;
      res_data  <= fq.out_data;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_bump;
    st_reg == ST_IDLE && cmd_take && !rep_active && rep_ok(cmd_code) &&
    cmd_allowed(cmd_code, mode, multi_tag, rep_cmd);
  endsequence

  sequence s_tmo;
    st_reg == ST_WAIT && !done_ev && tmo_hit;
  endsequence

  property p_loop_fast;
    s_bump |-> ##[1:2] head_req;
  endproperty
  a_loop_fast: assert property (p_loop_fast) else $error("repeat not issued in two cycles");

  property p_tmo_err;
    s_tmo |=> resp_err && resp_code == rfcs_pkg::RESP_TIMEOUT ##1 !resp_busy;
  endproperty
  a_tmo_err: assert property (p_tmo_err) else $error("timeout not reported");

  property p_tmo_only_full;
    tmo_en_reg |-> is_full(mode);
  endproperty
  a_tmo_only_full: assert property (p_tmo_only_full) else $error("timeout armed in basic mode");

  property p_echo;
    st_reg == ST_WAIT && done_ev && s2_reg[2] |=> resp_code == $past(head_cmd) && !resp_err;
  endproperty
  a_echo: assert property (p_echo) else $error("command code not echoed");

  property p_one_head;
    head_req && bus_mode && !rep_active |-> !head_all && head_addr == $past(cmd_head, 1);
  endproperty
  a_one_head: assert property (p_one_head) else $error("bus command not for one head");

  property p_all_heads;
    head_req && bus_mode && rep_active |-> head_all && fq.ring;
  endproperty
  a_all_heads: assert property (p_all_heads) else $error("continuous bus not broadcast");

  property p_cap;
    basic_mode |-> byte_cnt_reg <= BW'(rfcs_pkg::MAX_BYTES);
  endproperty
  a_cap: assert property (p_cap) else $error("basic mode passed byte limit");

  property p_stop;
    st_reg == ST_IDLE && cmd_take && cmd_code == rfcs_pkg::CMD_STOP |=> !rep_active ##1 !head_req;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end repetition");

  property p_clear;
    flush_reg |=> fq.count == '0 && !res_valid;
  endproperty
  a_clear: assert property (p_clear) else $error("buffer clear left data");

  property p_reject;
    st_reg == ST_IDLE && cmd_take && multi_tag && is_full(mode) &&
    cmd_code == rfcs_pkg::CMD_TAG_PROT |=> resp_err && resp_code == rfcs_pkg::RESP_REJECT;
  endproperty
  a_reject: assert property (p_reject) else $error("multi-tag command not rejected");

  property p_presence;
    st_reg == ST_WAIT && mode == rfcs_pkg::MODE_UHF_FULL |-> reader_on;
  endproperty
  a_presence: assert property (p_presence) else $error("reader off while running");
endmodule

// ### test/rfcs_head_model.sv
/*
  Behavioural head on the far side of the sequencer: after a set delay it streams a
  count of bytes, then toggles done. Assumes the bench sets delay and byte count.
*/
module rfcs_head_model (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        head_req,
  input  wire logic        head_abort,
  input  wire logic        head_hold,
  input  wire logic [15:0] dly,
  input  wire logic [7:0]  nb,
  output logic             done_tgl,
  output logic             dv_tgl,
  output logic [7:0]       data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        run_reg;
  logic [1:0]  ph_reg;
  logic [15:0] wait_reg;
  logic [7:0]  sent_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      run_reg  <= 1'b0;
      ph_reg   <= 2'h0;
      wait_reg <= 16'h0;
      sent_reg <= 8'h00;
      done_tgl <= 1'b0;
      dv_tgl   <= 1'b0;
      data     <= 8'h5a;
    end else if (head_abort) begin
      run_reg <= 1'b0;
    end else if (head_req) begin
      run_reg  <= 1'b1;
      wait_reg <= dly;
      sent_reg <= 8'h00;
      ph_reg   <= 2'h0;
    end else if (run_reg && wait_reg != 16'h0) begin
      wait_reg <= wait_reg - 16'h1;
    end else if (run_reg && sent_reg != nb) begin
      // Data settles two cycles before its toggle, so the synchroniser never sees it move.
      if (ph_reg == 2'h0 && !head_hold) begin
        data   <= sent_reg;
        ph_reg <= 2'h1;
      end else if (ph_reg == 2'h2) begin
        dv_tgl   <= ~dv_tgl;
        sent_reg <= sent_reg + 8'h01;
        ph_reg   <= 2'h3;
      end else if (ph_reg != 2'h0) begin
        ph_reg <= ph_reg + 2'h1;
      end
    end else if (run_reg) begin
      // A released data bus shows no stale byte.
      data     <= ~data;
      done_tgl <= ~done_tgl;
      run_reg  <= 1'b0;
    end
  end
endmodule

// ### test/rfcs_sequencer_tb.sv
/*
  Self-checking bench for the command sequencer; it plays the controller.
  Assumes the head model on the far side and one 200 MHz clock.
*/
module rfcs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  mode = 3'h1;
  logic        multi_tag = 1'b0;
  logic [7:0]  cmd_code = 8'h00;
  logic [7:0]  rep_cmd = 8'h02;
  logic [7:0]  loop_cnt = 8'h00;
  logic [4:0]  cmd_head = 5'h00;
  logic [15:0] tmo_cfg = 16'h0;
  logic        res_ready = 1'b0;
  logic [31:0] tag_in = 32'h0;
  logic [15:0] dly = 16'h4;
  logic [7:0]  nb = 8'h02;
  logic [7:0]  frag_size = 8'h00;
  logic [7:0]  resp_code, resp_loop, res_data, hd, head_cmd, req_cmd, frag_cnt;
  logic [31:0] tag_present;
  logic [4:0]  head_addr, req_addr;
  logic        resp_err, resp_busy, resp_trunc, rep_active, res_valid, head_req, head_abort;
  logic        head_all, head_hold, done_tgl, dv_tgl, req_all, reader_on, req_rdr;
  int          err_total = 0, checked = 0, abort_n = 0;
  initial forever #2.5 mclk = ~mclk;
  rfcs_sequencer i_rfcs_sequencer (.mclk(mclk), .rstn(rstn),
    .mode(mode), .multi_tag(multi_tag), .cmd_code(cmd_code), .rep_cmd(rep_cmd),
    .loop_cnt(loop_cnt), .frag_size(frag_size), .cmd_head(cmd_head), .tmo_cfg(tmo_cfg),
    .res_ready(res_ready), .resp_code(resp_code), .resp_loop(resp_loop), .resp_err(resp_err),
    .resp_busy(resp_busy), .resp_trunc(resp_trunc), .frag_cnt(frag_cnt), .rep_active(rep_active),
    .res_data(res_data), .res_valid(res_valid), .head_req(head_req), .head_abort(head_abort),
    .head_cmd(head_cmd), .head_addr(head_addr), .head_all(head_all), .head_hold(head_hold),
    .reader_on(reader_on), .head_done_tgl(done_tgl), .head_ok(1'b1), .head_dv_tgl(dv_tgl),
    .head_data(hd), .tag_in(tag_in), .tag_present(tag_present));
  rfcs_head_model i_rfcs_head_model (.mclk(mclk), .rstn(rstn), .head_req(head_req),
    .head_abort(head_abort), .head_hold(head_hold), .dly(dly), .nb(nb),
    .done_tgl(done_tgl), .dv_tgl(dv_tgl), .data(hd));
  // Pulses last a whole cycle, so the falling edge sees each exactly once.
  always @(negedge mclk) begin
    if (head_req === 1'b1) begin
      req_addr = head_addr;
      req_all = head_all;
      req_cmd = head_cmd;
      req_rdr = reader_on;
    end
    if (head_abort === 1'b1) abort_n++;
  end
  task automatic complete_run();
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(inout int n);
    @(negedge mclk);
    n++;
    if (n > 4000) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic send(input logic [7:0] code);
    @(negedge mclk);
    cmd_code = code;
    repeat (2) @(negedge mclk);
  endtask
  task automatic issue(input logic [7:0] code);
    int n;
    n = 0;
    send(code);
    while (resp_busy !== 1'b0) step(n);
  endtask
  task automatic t_cmd_set();
    logic [7:0] c [16] = '{rfcs_pkg::CMD_INVENTORY, rfcs_pkg::CMD_READ, rfcs_pkg::CMD_WRITE,
      rfcs_pkg::CMD_WRITE_VFY, rfcs_pkg::CMD_TAG_INFO, rfcs_pkg::CMD_BUF_READ,
      rfcs_pkg::CMD_BUF_CLEAR, rfcs_pkg::CMD_HEAD_IDENT, rfcs_pkg::CMD_HEAD_PW,
      rfcs_pkg::CMD_TAG_PW, rfcs_pkg::CMD_TAG_PROT, rfcs_pkg::CMD_ATTR_READ,
      rfcs_pkg::CMD_ATTR_WRITE, rfcs_pkg::CMD_ATTR_LOCK, rfcs_pkg::CMD_RESET,
      rfcs_pkg::CMD_IDLE};
    check(resp_code, 8'h00);
    res_ready = 1'b1;
    foreach (c[i]) begin
      issue(c[i]);
      check(resp_code, c[i]);
      check(resp_err, 1'b0);
    end
    issue(rfcs_pkg::CMD_INVENTORY);
    check(resp_code, rfcs_pkg::CMD_INVENTORY);
  endtask
  task automatic t_reject();
    issue(8'h7f);
    check(resp_code, rfcs_pkg::RESP_REJECT);
    multi_tag = 1'b1;
    issue(rfcs_pkg::CMD_HEAD_IDENT);
    check(resp_code, rfcs_pkg::RESP_REJECT);
    check(resp_err, 1'b1);
    issue(rfcs_pkg::CMD_TAG_PROT);
    check(resp_code, rfcs_pkg::RESP_REJECT);
    multi_tag = 1'b0;
    mode = rfcs_pkg::MODE_HF_BASIC;
    issue(rfcs_pkg::CMD_REPEAT);
    check(resp_code, rfcs_pkg::RESP_REJECT);
  endtask
  task automatic t_loop_timeout();
    int n;
    n = 0;
    mode = rfcs_pkg::MODE_HF_FULL;
    issue(rfcs_pkg::CMD_READ);
    loop_cnt = 8'h07;
    while (head_req !== 1'b1) step(n);
    check(n, 2);
    n = 0;
    while (resp_busy !== 1'b0) step(n);
    check(resp_loop, 8'h07);
    check(resp_code, rfcs_pkg::CMD_READ);
    dly = 16'hffff;
    tmo_cfg = 16'h1;
    n = abort_n;
    issue(rfcs_pkg::CMD_WRITE);
    check(resp_code, rfcs_pkg::RESP_TIMEOUT);
    check(resp_err, 1'b1);
    check(abort_n - n, 1);
    dly = 16'h4;
    tmo_cfg = 16'h0;
  endtask
  task automatic t_repeat();
    int n;
    n = 0;
    res_ready = 1'b0;
    nb = 8'h08;
    rep_cmd = rfcs_pkg::CMD_READ;
    send(rfcs_pkg::CMD_REPEAT);
    check(rep_active, 1'b1);
    while (head_hold !== 1'b1) step(n);
    check(req_cmd, rfcs_pkg::CMD_READ);
    // Reading past the buffer depth shows whether a byte was lost while the head was held.
    for (int k = 0; k < 24; k++) begin
      while (res_valid !== 1'b1) step(n);
      check(res_data, k % 8);
      res_ready = 1'b1;
      @(negedge mclk);
      res_ready = 1'b0;
      @(negedge mclk);
    end
    res_ready = 1'b1;
    issue(rfcs_pkg::CMD_STOP);
    while (resp_code !== rfcs_pkg::CMD_STOP) step(n);
    check(rep_active, 1'b0);
    res_ready = 1'b0;
    issue(rfcs_pkg::CMD_READ);
    while (res_valid !== 1'b1) step(n);
    issue(rfcs_pkg::CMD_BUF_CLEAR);
    check(res_valid, 1'b0);
  endtask
  task automatic t_bus_trunc();
    int n;
    n = 0;
    mode = rfcs_pkg::MODE_HF_BUS;
    cmd_head = 5'h1f;
    tag_in = 32'h8000_0011;
    res_ready = 1'b1;
    issue(rfcs_pkg::CMD_INVENTORY);
    check(req_addr, 5'h1f);
    check(req_all, 1'b0);
    check(tag_present, 32'h8000_0011);
    rep_cmd = rfcs_pkg::CMD_INVENTORY;
    send(rfcs_pkg::CMD_REPEAT);
    while (head_req !== 1'b1) step(n);
    check(head_all, 1'b1);
    issue(rfcs_pkg::CMD_STOP);
    while (resp_code !== rfcs_pkg::CMD_STOP) step(n);
    mode = rfcs_pkg::MODE_UHF_BASIC;
    nb = 8'h82;
    issue(rfcs_pkg::CMD_READ);
    check(resp_trunc, 1'b1);
    check(req_rdr, 1'b1);
    check(reader_on, 1'b0);
    mode = rfcs_pkg::MODE_UHF_FULL;
    frag_size = 8'h40;
    issue(rfcs_pkg::CMD_WRITE);
    check(resp_trunc, 1'b0);
    check(frag_cnt, 8'h02);
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    t_cmd_set();
    t_reject();
    t_loop_timeout();
    t_repeat();
    t_bus_trunc();
    complete_run();
  end
endmodule
